// File: rtl/acb_consts.svh
`ifndef ACB_CONSTS_SVH
`define ACB_CONSTS_SVH

// ****************************************
// Reset values and channel codes
// ****************************************
`define ACB_CHAN_RESET      3'h0
`define ACB_THR_RESET       8'h99
`define ACB_CHAN_TEMP       3'h0
`define ACB_CHAN_REF        3'h7

// ****************************************
// Control byte and result layout
// ****************************************
`define ACB_BYTE_SEL_MSB    7
`define ACB_BYTE_SEL_LSB    3
`define ACB_BYTE_CHAN_MSB   2
`define ACB_BYTE_BITS       8
`define ACB_RESULT_BITS     10

// ****************************************
// Timing
// ****************************************
`define ACB_CLK_PERIOD_NS   10
`define ACB_CONV_ANA_NS     9000
`define ACB_CONV_TEMP_NS    27000
`define ACB_CONV_ANA_CYC    (`ACB_CONV_ANA_NS / `ACB_CLK_PERIOD_NS)
`define ACB_CONV_TEMP_CYC   (`ACB_CONV_TEMP_NS / `ACB_CLK_PERIOD_NS)

`endif

// File: rtl/acb_pkg.sv
`default_nettype none

`include "acb_consts.svh"

package acb_pkg;

	typedef enum logic [1:0] {
		ACB_IDLE  = 2'b00,
		ACB_CONV  = 2'b01,
		ACB_PDOWN = 2'b10
	} acb_conv_t;

	typedef struct packed {
		acb_conv_t  st;
		logic [11:0] cnt;
		logic [2:0]  chan;
		logic [2:0]  conv_chan;
		logic [7:0]  thr;
		logic [9:0]  result;
		logic [7:0]  sh_in;
		logic [3:0]  bits_in;
		logic [9:0]  sh_out;
		logic [3:0]  bits_out;
		logic        alarm_n;
		logic        sclk_d;
		logic        rw_d;
		logic        cs_d;
	} acb_state_t;

endpackage : acb_pkg

`default_nettype wire

// File: rtl/acb_sync.sv
`timescale 1ns/10ps
`default_nettype none

module acb_sync #(
	parameter int                 WIDTH     = 4,
	parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// ****************************************
	// Two-stage synchroniser, first stage private
	// ****************************************
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule : acb_sync

`default_nettype wire

// File: rtl/acb_top.sv
`timescale 1ns/10ps
`default_nettype none

`include "acb_consts.svh"

// Overview of operation
// - Host writes an 8-bit control byte; upper bits pick its target register.
// - Byte with five zero MSBs loads only its three LSBs as channel.
// - 3-bit channel: 001-100 analog inputs one to four, 111 bandgap reference.
// - Channel code 000 routes the converter to the temperature sensor.
// - Channel register resets to zero, selecting the temperature sensor.
// - Byte with any of five MSBs set loads whole byte as threshold.
// - After temperature conversion, result MSBs above threshold drive alarm low.
// - Alarm returns high after a read or a temperature below threshold.
// - Threshold resets to 153, an alarm temperature of 50 degrees.
// - Falling convert-start puts sampler in hold and starts conversion.
// - BUSY high 9 us for analog, 27 us for temperature sensor.
// - Conversion timed internally; serial clock only moves port data.
// - Sampler returns to track at the end of each conversion.
// - Data shifts out on falling and is sampled on rising serial clock.
// - Rising read/write select starts a read and releases the alarm.
// - Convert-start low at conversion end powers down until its rising edge.
module acb_top
	import acb_pkg::*;
#(
	parameter int CONV_ANA_CYC  = `ACB_CONV_ANA_CYC,
	parameter int CONV_TEMP_CYC = `ACB_CONV_TEMP_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       conversion_start_n,
	input  wire logic       rd_wr_sel,
	input  wire logic       sclk,
	input  wire logic       sdio_in,
	output logic            sdio_out,
	output logic            sdio_oe,
	input  wire logic [9:0] adc_code,
	output logic            busy,
	output logic            overtemp_alarm_n,
	output logic            track_hold,
	output logic            power_down,
	output logic [2:0]      channel_select,
	output logic [3:0]      ain_sel,
	output logic            temp_sel,
	output logic            ref_sel
);

	import acb_pkg::*;

	// ****************************************
	// Constants
	// ****************************************
	localparam acb_state_t RESET_STATE = '{
		st:        ACB_IDLE,
		cnt:       12'h000,
		chan:      `ACB_CHAN_RESET,
		conv_chan: `ACB_CHAN_RESET,
		thr:       `ACB_THR_RESET,
		result:    10'h000,
		sh_in:     8'h00,
		bits_in:   4'h0,
		sh_out:    10'h000,
		bits_out:  4'h0,
		alarm_n:   1'b1,
		sclk_d:    1'b0,
		rw_d:      1'b0,
		cs_d:      1'b1
	};

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [3:0] ain_decode(input logic [2:0] code);
		logic [3:0] sel;
		sel = 4'h0;
		case (code)
			3'h1:    sel = 4'h1;
			3'h2:    sel = 4'h2;
			3'h3:    sel = 4'h4;
			3'h4:    sel = 4'h8;
			default: sel = 4'h0;
		endcase
		return sel;
	endfunction : ain_decode

	function automatic logic [11:0] conv_len(input logic [2:0] code);
		if (code == `ACB_CHAN_TEMP)
			return 12'(CONV_TEMP_CYC - 1);
		else
			return 12'(CONV_ANA_CYC - 1);
	endfunction : conv_len

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [3:0] pins_s;
	logic       cs_s;
	logic       rw_s;
	logic       sclk_s;
	logic       din_s;

	// Link clock is sampled, not used as a clock: edges lag pins by ~3 cycles
	acb_sync #(
		.WIDTH     (4),
		.RESET_VAL (4'h8)
	) u_sync (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.async_in ({conversion_start_n, rd_wr_sel, sclk, sdio_in}),
		.sync_out (pins_s)
	);

	assign cs_s   = pins_s[3];
	assign rw_s   = pins_s[2];
	assign sclk_s = pins_s[1];
	assign din_s  = pins_s[0];

	// ****************************************
	// State
	// ****************************************
	acb_state_t s_q;
	acb_state_t s_d;

	logic       sclk_rise;
	logic       sclk_fall;
	logic       rw_rise;
	logic       cs_fall;
	logic       cs_rise;
	logic [7:0] wr_byte;
	logic       wr_done;
	logic       conv_end;
	logic       temp_gt;
	logic       temp_lt;

	assign sclk_rise = sclk_s & ~s_q.sclk_d;
	assign sclk_fall = ~sclk_s & s_q.sclk_d;
	assign rw_rise   = rw_s & ~s_q.rw_d;
	assign cs_fall   = ~cs_s & s_q.cs_d;
	assign cs_rise   = cs_s & ~s_q.cs_d;
	assign wr_byte   = {s_q.sh_in[6:0], din_s};
	assign wr_done   = ~rw_s & sclk_rise & (s_q.bits_in == 4'h7);
	assign conv_end  = (s_q.st == ACB_CONV) && (s_q.cnt == 12'h000);
	assign temp_gt   = adc_code[9:2] > s_q.thr;
	assign temp_lt   = adc_code[9:2] < s_q.thr;

	always_comb begin
		s_d        = s_q;
		s_d.sclk_d = sclk_s;
		s_d.rw_d   = rw_s;
		s_d.cs_d   = cs_s;

		// Serial write, bits taken on rising clock
		if (rw_s) begin
			s_d.bits_in = 4'h0;
		end else if (sclk_rise) begin
			s_d.sh_in = wr_byte;
			if (s_q.bits_in == 4'h7) begin
				s_d.bits_in = 4'h0;
				// Upper five bits choose the register
				if (wr_byte[`ACB_BYTE_SEL_MSB:`ACB_BYTE_SEL_LSB] == 5'h00)
					s_d.chan = wr_byte[`ACB_BYTE_CHAN_MSB:0];
				else
					s_d.thr = wr_byte;
			end else begin
				s_d.bits_in = s_q.bits_in + 4'h1;
			end
		end

		// Serial read, MSB first, shifted on falling clock
		if (!rw_s) begin
			s_d.bits_out = 4'h0;
		end else if (rw_rise) begin
			s_d.sh_out   = s_q.result;
			s_d.bits_out = 4'ha;
		end else if (sclk_fall && s_q.bits_out != 4'h0) begin
			s_d.sh_out   = {s_q.sh_out[8:0], 1'b0};
			s_d.bits_out = s_q.bits_out - 4'h1;
		end

		// Read edge releases alarm; a same-cycle set below wins
		if (rw_rise)
			s_d.alarm_n = 1'b1;

		// Conversion sequencer on the internal clock
		case (s_q.st)
			ACB_IDLE: begin
				if (cs_fall) begin
					s_d.st        = ACB_CONV;
					s_d.conv_chan = s_q.chan;
					s_d.cnt       = conv_len(s_q.chan);
				end
			end
			ACB_CONV: begin
				if (s_q.cnt == 12'h000) begin
					s_d.result = adc_code;
					// Still-low start means power down as BUSY falls
					s_d.st     = cs_s ? ACB_IDLE : ACB_PDOWN;
					if (s_q.conv_chan == `ACB_CHAN_TEMP) begin
						if (temp_gt)
							s_d.alarm_n = 1'b0;
						else if (temp_lt)
							s_d.alarm_n = 1'b1;
					end
				end else begin
					s_d.cnt = s_q.cnt - 12'h001;
				end
			end
			ACB_PDOWN: begin
				if (cs_rise)
					s_d.st = ACB_IDLE;
			end
			default: begin
				s_d.st = ACB_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			s_q <= RESET_STATE;
		else
			s_q <= s_d;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign busy             = (s_q.st == ACB_CONV);
	assign track_hold       = (s_q.st == ACB_CONV);
	assign power_down       = (s_q.st == ACB_PDOWN);
	assign overtemp_alarm_n = s_q.alarm_n;
	assign sdio_out         = s_q.sh_out[9];
	assign sdio_oe          = rw_s & (s_q.bits_out != 4'h0);
	// Mux follows the live register; a mid-conversion change is the host's risk
	assign channel_select   = s_q.chan;
	assign ain_sel          = ain_decode(s_q.chan);
	assign temp_sel         = (s_q.chan == `ACB_CHAN_TEMP);
	assign ref_sel          = (s_q.chan == `ACB_CHAN_REF);

	// ****************************************
	// Assertions
	// ****************************************
	logic [11:0] busy_len_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			busy_len_q <= 12'h000;
		else
			busy_len_q <= busy ? busy_len_q + 12'h001 : 12'h000;
	end

	property p_busy_len;
		@(posedge ref_clk) disable iff (!nrst)
		$fell(busy) |-> busy_len_q == ((s_q.conv_chan == `ACB_CHAN_TEMP) ?
			12'(CONV_TEMP_CYC) : 12'(CONV_ANA_CYC));
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

	property p_chan_load;
		@(posedge ref_clk) disable iff (!nrst)
		wr_done && wr_byte[7:3] == 5'h00 |=> channel_select == $past(wr_byte[2:0]);
	endproperty
	a_chan_load: assert property (p_chan_load) else $error("channel not loaded");

	property p_thr_load;
		@(posedge ref_clk) disable iff (!nrst)
		wr_done && wr_byte[7:3] != 5'h00 |=> s_q.thr == $past(wr_byte) && $stable(s_q.chan);
	endproperty
	a_thr_load: assert property (p_thr_load) else $error("threshold not loaded");

	property p_alarm_set;
		@(posedge ref_clk) disable iff (!nrst)
		conv_end && s_q.conv_chan == `ACB_CHAN_TEMP && temp_gt |=> !overtemp_alarm_n;
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("alarm not set");

	property p_alarm_release;
		@(posedge ref_clk) disable iff (!nrst)
		rw_rise && !conv_end |=> overtemp_alarm_n;
	endproperty
	a_alarm_release: assert property (p_alarm_release) else $error("alarm not released");

	property p_start_hold;
		@(posedge ref_clk) disable iff (!nrst)
		cs_fall && s_q.st == ACB_IDLE |=> track_hold && busy ##1 busy;
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("no hold at start");

	property p_end_track;
		@(posedge ref_clk) disable iff (!nrst)
		$fell(busy) |-> !track_hold && s_q.result == $past(adc_code);
	endproperty
	a_end_track: assert property (p_end_track) else $error("no track at end");

	property p_pdown;
		@(posedge ref_clk) disable iff (!nrst)
		conv_end && !cs_s |=> power_down until cs_rise;
	endproperty
	a_pdown: assert property (p_pdown) else $error("power down wrong");

	property p_read_msb;
		@(posedge ref_clk) disable iff (!nrst)
		rw_rise |=> sdio_oe && sdio_out == $past(s_q.result[9]);
	endproperty
	a_read_msb: assert property (p_read_msb) else $error("read msb wrong");

	property p_chan_stable;
		@(posedge ref_clk) disable iff (!nrst)
		!wr_done |=> $stable(channel_select);
	endproperty
	a_chan_stable: assert property (p_chan_stable) else $error("channel changed");

endmodule : acb_top

`default_nettype wire

// File: test/acb_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Host serial master
// ****************************************
module acb_host_model (
	input  wire logic ref_clk,
	input  wire logic sdio,
	output logic      rd_wr_sel,
	output logic      sclk,
	output logic      drv,
	output logic      drv_en
);
	// Serial clock rests low between frames
	initial begin
		rd_wr_sel = 1'b0;
		sclk      = 1'b0;
		drv       = 1'b0;
		drv_en    = 1'b0;
	end

	task automatic wr(input logic [7:0] b);
		@(posedge ref_clk);
		#1 rd_wr_sel = 1'b0;
		drv_en = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			drv = b[i];
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
		drv_en = 1'b0;
	endtask : wr

	task automatic rd(output logic [9:0] w);
		@(posedge ref_clk);
		#1 rd_wr_sel = 1'b1;
		for (int i = 9; i >= 0; i--) begin
			#80 sclk = 1'b1;
			w[i] = sdio;
			#80 sclk = 1'b0;
		end
		rd_wr_sel = 1'b0;
	endtask : rd
endmodule : acb_host_model

`default_nettype wire

// File: test/tb_adc_control_byte_and_overtemp_alarm.sv
`timescale 1ns/10ps
`default_nettype none

module tb_adc_control_byte_and_overtemp_alarm;
	logic       ref_clk, nrst, cs_n, rw, sclk, drv, drv_en, float_q;
	logic       sd_out, sd_oe, busy, alarm_n, th, pd, t_sel, r_sel;
	logic [9:0] adc, w;
	logic [2:0] chan;
	logic [3:0] ain;
	wire        sdio = sd_oe ? sd_out : (drv_en ? drv : float_q);
	int         n_fail, n_compared, cyc;

	acb_top #(.CONV_ANA_CYC(20), .CONV_TEMP_CYC(60)) i_dut (
		.ref_clk(ref_clk), .nrst(nrst), .conversion_start_n(cs_n), .rd_wr_sel(rw),
		.sclk(sclk), .sdio_in(sdio), .sdio_out(sd_out), .sdio_oe(sd_oe), .adc_code(adc),
		.busy(busy), .overtemp_alarm_n(alarm_n), .track_hold(th), .power_down(pd),
		.channel_select(chan), .ain_sel(ain), .temp_sel(t_sel), .ref_sel(r_sel));

	acb_host_model i_host (.ref_clk(ref_clk), .sdio(sdio), .rd_wr_sel(rw), .sclk(sclk),
		.drv(drv), .drv_en(drv_en));

	// ****************************************
	// Clock, floating line, timeout
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Released line toggles so a stale value cannot match
	always @(posedge ref_clk) float_q <= ~float_q;

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (n_fail == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_chan(input logic [2:0] c);
		chk(10'(chan), 10'(c));
		chk(10'(ain), (c >= 3'h1 && c <= 3'h4) ? 10'h1 << (c - 3'h1) : 10'h0);
		chk(10'(t_sel), 10'(c == 3'h0));
		chk(10'(r_sel), 10'(c == 3'h7));
	endtask : chk_chan

	// Start, time BUSY, optionally hold start low into power-down
	task automatic conv(input logic [9:0] code, input int n_exp, input logic hold);
		int n;
		adc = code;
		repeat (50) @(posedge ref_clk);
		#1 cs_n = 1'b0;
		for (int i = 0; i < 10 && busy !== 1'b1; i++) @(posedge ref_clk) #1;
		chk(10'(th), 10'h1);
		if (!hold) cs_n = 1'b1;
		n = 0;
		while (busy === 1'b1 && n < 5000) begin
			@(posedge ref_clk) #1;
			n++;
		end
		chk(10'(n), 10'(n_exp));
		chk(10'(th), 10'h0);
		@(posedge ref_clk) #1;
		chk(10'(pd), 10'(hold));
		if (hold) begin
			cs_n = 1'b1;
			repeat (5) @(posedge ref_clk) #1;
			chk(10'(pd), 10'h0);
		end
	endtask : conv

	// ****************************************
	// Rows: control byte and channel it leaves
	// ****************************************
	logic [7:0] row_b [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h05, 8'h00, 8'h08};
	logic [2:0] row_c [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h5, 3'h0, 3'h0};

	initial begin
		n_fail = 0;
		n_compared = 0;
		cyc = 0;
		float_q = 1'b0;
		nrst = 1'b0;
		cs_n = 1'b1;
		adc = 10'h0;
		repeat (4) @(posedge ref_clk);
		#1 nrst = 1'b1;
		repeat (3) @(posedge ref_clk) #1;
		chk_chan(3'h0);
		chk(10'(alarm_n), 10'h1);
		chk(10'(busy), 10'h0);
		// Default threshold 153: one step above alarms, equal does not
		conv({8'd153, 2'b11}, 60, 1'b0);
		chk(10'(alarm_n), 10'h1);
		conv({8'd154, 2'b00}, 60, 1'b0);
		chk(10'(alarm_n), 10'h0);
		i_host.rd(w);
		chk(w, {8'd154, 2'b00});
		chk(10'(alarm_n), 10'h1);
		// Last shift and read end reach the port through the synchroniser
		repeat (4) @(posedge ref_clk) #1;
		chk(10'(sd_oe), 10'h0);
		for (int i = 0; i < 8; i++) begin
			i_host.wr(row_b[i]);
			repeat (6) @(posedge ref_clk) #1;
			chk_chan(row_c[i]);
		end
		// Threshold of 8 from last row replaced by 128: 25 degrees encoded
		i_host.wr(8'(25 + 103));
		conv({8'd129, 2'b01}, 60, 1'b1);
		chk(10'(alarm_n), 10'h0);
		conv({8'd127, 2'b10}, 60, 1'b0);
		chk(10'(alarm_n), 10'h1);
		// Analog channel: short conversion, alarm untouched
		i_host.wr(8'h01);
		conv(10'h3ff, 20, 1'b0);
		chk(10'(alarm_n), 10'h1);
		i_host.rd(w);
		chk(w, 10'h3ff);
		// Mid-run reset restores channel 0 and the 153 threshold
		i_host.wr(8'hff);
		nrst = 1'b0;
		repeat (2) @(posedge ref_clk) #1;
		nrst = 1'b1;
		repeat (3) @(posedge ref_clk) #1;
		chk_chan(3'h0);
		conv({8'd154, 2'b00}, 60, 1'b0);
		chk(10'(alarm_n), 10'h0);
		stop_test();
	end
endmodule : tb_adc_control_byte_and_overtemp_alarm

`default_nettype wire
